// file: rtl/bms_boot_ctrl.sv
// Boot mode selection and reset-entry sequencer
//
// Operation
// RULE_01: EPROM strap high, link strap low selects 8-bit EPROM boot.
// RULE_02: EPROM strap low: link strap and select pin input pick mode.
// RULE_03: Straps 0 0 1 select host processor boot.
// RULE_04: Straps 0 1 1 select link port boot.
// RULE_05: Straps 0 0 0 skip boot, run straight from external memory.
// RULE_06: Board never applies 0 1 0 or 1 1 x; those are reserved.
// RULE_07: In EPROM mode the select pin drives boot memory chip select.
// RULE_08: Only the current bus master drives the select pin.
// RULE_09: Select pin may float only as EPROM-mode output, else input.
// RULE_10: Link strap low never yields link port boot.
// RULE_11: Board hardwires the straps and never changes them in use.
// RULE_12: Reset gives a known state, then execution from reset vector.
// RULE_13: System holds reset low during power-up.
// RULE_14: One instruction per input clock; clock never stopped or slowed.
// RULE_15: Straps sampled at reset release; mode held until next reset.
module bsl_boot_ctrl #(
    parameter logic [23:0] P_RESET_VECTOR = 24'h000000,
    parameter int unsigned P_ADDR_W       = 24
) (
    input  wire logic                  i_clock,
    input  wire logic                  i_rst_n,
    input  wire logic                  i_eprom_boot_strap,
    input  wire logic                  i_link_boot_strap,
    input  wire logic                  i_boot_select_pin,
    output logic                       o_boot_select_pin,
    output logic                       o_boot_select_oe,
    input  wire logic                  i_bus_master,
    input  wire logic                  i_boot_mem_req,
    input  wire logic                  i_boot_done,
    output bsl_pkg::bsl_mode_t         o_boot_mode,
    output logic                       o_mode_valid,
    output logic                       o_reserved_err,
    output logic                       o_boot_load,
    output logic                       o_core_start,
    output logic                       o_instr_cycle_en,
    output logic [P_ADDR_W-1:0]        o_fetch_addr,
    output logic                       o_strap_changed
);
    import bsl_pkg::*;

    // Complete state of the sequencer
    typedef struct packed {
        bsl_state_t             fsm;
        logic [SETTLE_W-1:0]    settle_cnt;
        bsl_mode_t              mode;
        logic [STRAP_WIDTH-1:0] straps;
        logic                   mode_valid;
        logic                   reserved_err;
        logic                   boot_load;
        logic                   core_start;
        logic                   run;
        logic [P_ADDR_W-1:0]    fetch_addr;
        logic                   strap_changed;
    } bsl_ctrl_t;

    localparam bsl_ctrl_t CTRL_RESET = '{
        fsm:           BSL_ST_IDLE,
        settle_cnt:    '0,
        mode:          BSL_MODE_NONE,
        straps:        STRAP_RESET,
        mode_valid:    1'b0,
        reserved_err:  1'b0,
        boot_load:     1'b0,
        core_start:    1'b0,
        run:           1'b0,
        fetch_addr:    '0,
        strap_changed: 1'b0
    };

    bsl_ctrl_t  state_reg;
    bsl_ctrl_t  state_next;
    bsl_link_if link ();

    // Vector cut to the fetch address width on purpose
    localparam logic [P_ADDR_W-1:0] RESET_ADDR = P_ADDR_W'(P_RESET_VECTOR);

    logic [STRAP_WIDTH-1:0] raw_straps;
    bsl_mode_t              decoded;
    logic [STRAP_WIDTH-1:0] watch_mask;

    // Pin order into the synchroniser is {eprom, link, select}
    assign raw_straps = {i_eprom_boot_strap, i_link_boot_strap,
                         i_boot_select_pin};

    bsl_strap_sync u_sync (
        .i_clock  (i_clock),
        .i_rst_n  (i_rst_n),
        .i_straps (raw_straps),
        .link     (link.sync_mp)
    );

    // Decode of the live synchronised straps
    assign decoded = bsl_decode(link.straps_s);  // RULE_02 RULE_10

    // In EPROM mode the select pin is our own output, so do not watch it
    assign watch_mask = state_reg.mode == BSL_MODE_EPROM ? 3'h6 : 3'h7;

    // Sequencer: settle, latch, optional load, then run, or halt on reserved straps
    always_comb begin
        state_next            = state_reg;
        state_next.core_start = 1'b0;
        unique case (state_reg.fsm)
            BSL_ST_IDLE: begin
                // First edge after reset release; straps still settling
                state_next.settle_cnt = '0;
                state_next.fsm        = BSL_ST_SETTLE;
            end
            BSL_ST_SETTLE: begin
                // Wait until the pins have crossed both sync stages
                if (state_reg.settle_cnt == SETTLE_LAST) begin
                    state_next.fsm = BSL_ST_LATCH;
                end else begin
                    state_next.settle_cnt = state_reg.settle_cnt + 1'b1;
                end
            end
            BSL_ST_LATCH: begin
                // One-shot capture; mode is frozen from here on
                state_next.straps     = link.straps_s;  // RULE_15
                state_next.mode       = decoded;  // RULE_01 RULE_03
                state_next.mode_valid = 1'b1;
                if (decoded == BSL_MODE_RESERVED) begin
                    // Reserved straps: stay quiet rather than guess
                    state_next.reserved_err = 1'b1;  // RULE_06
                    state_next.fsm          = BSL_ST_HALT;
                end else if (bsl_is_boot(decoded)) begin
                    state_next.boot_load = 1'b1;  // RULE_04
                    state_next.fsm       = BSL_ST_LOAD;
                end else begin
                    // No boot: fetch from external memory at once
                    state_next.fetch_addr = RESET_ADDR;  // RULE_05
                    state_next.core_start = 1'b1;  // RULE_12
                    state_next.run        = 1'b1;
                    state_next.fsm        = BSL_ST_RUN;
                end
            end
            BSL_ST_LOAD: begin
                // Loader owns memory until it reports completion
                if (i_boot_done) begin
                    state_next.boot_load  = 1'b0;
                    state_next.fetch_addr = RESET_ADDR;  // RULE_12
                    state_next.core_start = 1'b1;
                    state_next.run        = 1'b1;
                    state_next.fsm        = BSL_ST_RUN;
                end
            end
            BSL_ST_RUN: begin
                // One instruction slot per clock from here on
                state_next.run = 1'b1;  // RULE_14
            end
            BSL_ST_HALT: begin
                state_next.run = 1'b0;
            end
            default: begin
                // Illegal code: fall back to a fresh strap sample
                state_next = CTRL_RESET;
            end
        endcase
        // Straps should be hardwired; flag later movement, select pin excepted in EPROM mode
        if (state_reg.mode_valid &&
            ((link.straps_s ^ state_reg.straps) & watch_mask) != 3'h0) begin
            state_next.strap_changed = 1'b1;
        end
    end

    // Asynchronous reset puts the sequencer in its known state
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_reg <= CTRL_RESET;  // RULE_12 RULE_13
        end else begin
            state_reg <= state_next;
        end
    end

    // Chip select is asked for while any boot load is active and memory is requested
    assign link.eprom_mode = state_reg.mode_valid &&
                             state_reg.mode == BSL_MODE_EPROM;  // RULE_07
    assign link.cs_req     = state_reg.boot_load && i_boot_mem_req;
    assign link.bus_master = i_bus_master;  // RULE_08

    bsl_pin_drive u_drive (
        .i_clock (i_clock),
        .i_rst_n (i_rst_n),
        .link    (link.drive_mp)
    );

    // Outputs, all from flip-flops
    assign o_boot_select_pin = link.pin_out;
    assign o_boot_select_oe  = link.pin_oe;  // RULE_09
    assign o_boot_mode       = state_reg.mode;
    assign o_mode_valid      = state_reg.mode_valid;
    assign o_reserved_err    = state_reg.reserved_err;
    assign o_boot_load       = state_reg.boot_load;
    assign o_core_start      = state_reg.core_start;
    assign o_instr_cycle_en  = state_reg.run;
    assign o_fetch_addr      = state_reg.fetch_addr;
    assign o_strap_changed   = state_reg.strap_changed;

endmodule : bsl_boot_ctrl

// file: pkg/bms_pkg.sv
// Shared constants, types and decode helpers of the boot mode selector
package bsl_pkg;

    // Boot modes resolved from the straps at reset release
    typedef enum logic [2:0] {
        BSL_MODE_NONE     = 3'h0,
        BSL_MODE_HOST     = 3'h1,
        BSL_MODE_LINK     = 3'h2,
        BSL_MODE_EPROM    = 3'h3,
        BSL_MODE_RESERVED = 3'h4
    } bsl_mode_t;

    // Sequencer states, Gray coded along idle-settle-latch-load-run
    typedef enum logic [2:0] {
        BSL_ST_IDLE   = 3'b000,
        BSL_ST_SETTLE = 3'b001,
        BSL_ST_LATCH  = 3'b011,
        BSL_ST_LOAD   = 3'b010,
        BSL_ST_RUN    = 3'b110,
        BSL_ST_HALT   = 3'b111
    } bsl_state_t;

    // Bit positions of the synchronised strap vector
    localparam int unsigned STRAP_SEL_BIT   = 0;
    localparam int unsigned STRAP_LINK_BIT  = 1;
    localparam int unsigned STRAP_EPROM_BIT = 2;
    localparam int unsigned STRAP_WIDTH     = 3;

    // Reset values
    localparam logic [STRAP_WIDTH-1:0] STRAP_RESET = 3'h0;
    localparam logic                   PIN_IDLE    = 1'b1;

    // Cycles to wait after reset release so the synchroniser is filled
    localparam int unsigned SETTLE_CYCLES = 3;
    localparam int unsigned SETTLE_W      = 2;
    localparam logic [SETTLE_W-1:0] SETTLE_LAST =
        SETTLE_W'(SETTLE_CYCLES - 1);

    // Strap vector {eprom, link, select} to boot mode
    function automatic bsl_mode_t bsl_decode(
        input logic [STRAP_WIDTH-1:0] straps
    );
        bsl_mode_t mode;
        mode = BSL_MODE_RESERVED;
        unique case (straps)
            3'h0:    mode = BSL_MODE_NONE;
            3'h1:    mode = BSL_MODE_HOST;
            3'h3:    mode = BSL_MODE_LINK;
            3'h4,
            3'h5:    mode = BSL_MODE_EPROM;
            default: mode = BSL_MODE_RESERVED;
        endcase
        return mode;
    endfunction : bsl_decode

    // Modes that load a program before the core runs
    function automatic logic bsl_is_boot(input bsl_mode_t mode);
        return (mode == BSL_MODE_HOST) || (mode == BSL_MODE_LINK) ||
               (mode == BSL_MODE_EPROM);
    endfunction : bsl_is_boot

endpackage : bsl_pkg

// file: pkg/bms_link_if.sv
// Internal bundle between strap synchroniser, sequencer and pin driver
interface bsl_link_if;
    import bsl_pkg::*;

    logic [STRAP_WIDTH-1:0] straps_s;    // Synchronised straps
    logic                   eprom_mode;  // Latched mode is EPROM boot
    logic                   cs_req;      // Boot memory access wanted
    logic                   bus_master;  // This processor owns the bus
    logic                   pin_out;     // Chip select level, low active
    logic                   pin_oe;      // Pin driven

    modport sync_mp  (output straps_s);
    modport ctrl_mp  (input straps_s, output eprom_mode, output cs_req,
                      output bus_master, input pin_out, input pin_oe);
    modport drive_mp (input eprom_mode, input cs_req, input bus_master,
                      output pin_out, output pin_oe);
endinterface : bsl_link_if

// file: rtl/bms_strap_sync.sv
// Two-stage synchroniser for the strap pins
module bsl_strap_sync (
    input  wire logic                            i_clock,
    input  wire logic                            i_rst_n,
    input  wire logic [bsl_pkg::STRAP_WIDTH-1:0] i_straps,
    bsl_link_if.sync_mp                          link
);
    import bsl_pkg::*;

    typedef struct packed {
        logic [STRAP_WIDTH-1:0] stage1;
        logic [STRAP_WIDTH-1:0] stage2;
    } bsl_sync_t;

    bsl_sync_t state_reg;
    bsl_sync_t state_next;

    // First stage feeds only the second one
    always_comb begin
        state_next        = state_reg;
        state_next.stage1 = i_straps;
        state_next.stage2 = state_reg.stage1;
    end

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_reg <= '{stage1: STRAP_RESET, stage2: STRAP_RESET};
        end else begin
            state_reg <= state_next;
        end
    end

    assign link.straps_s = state_reg.stage2;

endmodule : bsl_strap_sync

// file: rtl/bms_pin_drive.sv
// Registered chip select driver for the shared boot-select pin
module bsl_pin_drive (
    input  wire logic    i_clock,
    input  wire logic    i_rst_n,
    bsl_link_if.drive_mp link
);
    import bsl_pkg::*;

    typedef struct packed {
        logic pin_out;
        logic pin_oe;
    } bsl_drive_t;

    bsl_drive_t state_reg;
    bsl_drive_t state_next;

    // Only an EPROM-mode bus master ever enables the driver
    always_comb begin
        state_next        = state_reg;
        state_next.pin_oe = link.eprom_mode & link.bus_master;  // RULE_08
        state_next.pin_out = ~(link.cs_req & link.bus_master);  // RULE_07
        if (!link.eprom_mode) begin
            state_next.pin_out = PIN_IDLE;  // RULE_09
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_reg <= '{pin_out: PIN_IDLE, pin_oe: 1'b0};
        end else begin
            state_reg <= state_next;
        end
    end

    assign link.pin_out = state_reg.pin_out;
    assign link.pin_oe  = state_reg.pin_oe;

endmodule : bsl_pin_drive

// file: bench/bms_board_model.sv
// Board straps, select pin wire and boot loader partner of the selector
module bsl_board_model (
    input  wire logic       i_clock,
    input  wire logic [2:0] i_straps,
    input  wire logic [7:0] i_load_len,
    input  wire logic       i_pin_out,
    input  wire logic       i_pin_oe,
    input  wire logic       i_boot_load,
    output logic            o_eprom_strap,
    output logic            o_link_strap,
    output logic            o_select_wire,
    output logic            o_mem_req = 1'b0,
    output logic            o_boot_done = 1'b0
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [7:0] count_reg = 8'h00;

    // Straps are hardwired resistors: {eprom, link, select}
    assign o_eprom_strap = i_straps[2];
    assign o_link_strap  = i_straps[1];
    // Driver wins over the strap resistor only while the pin is enabled
    assign o_select_wire = i_pin_oe ? i_pin_out : i_straps[0];

    // Loader asks for memory, then reports done until the load ends
    always @(negedge i_clock) begin
        if (!i_boot_load) begin
            count_reg   <= 8'h00;
            o_mem_req   <= 1'b0;
            o_boot_done <= 1'b0;
        end else begin
            count_reg   <= count_reg + 8'h01;
            o_mem_req   <= (count_reg < i_load_len);
            o_boot_done <= (count_reg >= i_load_len);
        end
    end
endmodule : bsl_board_model

// file: bench/bms_boot_ctrl_assertions.sv
// Port level checks of the boot mode selector
module bsl_boot_ctrl_assertions #(
    parameter logic [23:0] P_RESET_VECTOR = 24'h000000,
    parameter int unsigned P_ADDR_W       = 24
) (
    input wire logic               i_clock,
    input wire logic               i_rst_n,
    input wire logic               i_eprom_boot_strap,
    input wire logic               i_link_boot_strap,
    input wire logic               i_bus_master,
    input wire logic               i_boot_mem_req,
    input wire logic               i_boot_done,
    input wire logic               o_boot_select_pin,
    input wire logic               o_boot_select_oe,
    input wire bsl_pkg::bsl_mode_t o_boot_mode,
    input wire logic               o_mode_valid,
    input wire logic               o_reserved_err,
    input wire logic               o_boot_load,
    input wire logic               o_core_start,
    input wire logic               o_instr_cycle_en,
    input wire logic [P_ADDR_W-1:0] o_fetch_addr
);
    timeunit 1ns;
    timeprecision 1ns;
    import bsl_pkg::*;

    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);

    // Core start steps: running at the vector, then pulse gone
    sequence s_at_vector;
        o_instr_cycle_en && (o_fetch_addr == P_RESET_VECTOR);
    endsequence
    sequence s_pulse_over;
        !o_core_start && o_instr_cycle_en;
    endsequence

    a_oe_eprom_only:
        assert property (o_boot_select_oe |-> o_boot_mode == BSL_MODE_EPROM)
        else $error("Select pin driven outside eprom mode");
    a_oe_bus_master:
        assert property (o_boot_select_oe |-> $past(i_bus_master))
        else $error("Select pin driven without bus ownership");
    a_cs_on_request:
        assert property ((o_boot_mode == BSL_MODE_EPROM) && o_boot_load &&
            i_boot_mem_req && i_bus_master |=> !o_boot_select_pin)
        else $error("Chip select not asserted on request");
    a_pin_idle_high:
        assert property (o_boot_mode != BSL_MODE_EPROM |-> o_boot_select_pin)
        else $error("Select output active outside eprom mode");
    a_mode_held:
        assert property (o_mode_valid |=> o_mode_valid && $stable(o_boot_mode))
        else $error("Boot mode moved after latch");
    a_eprom_decode:
        assert property ($rose(o_mode_valid) |->
            (o_boot_mode == BSL_MODE_EPROM) ==
            ($past(i_eprom_boot_strap, 3) && !$past(i_link_boot_strap, 3)))
        else $error("Eprom mode decode wrong");
    a_link_decode:
        assert property ($rose(o_mode_valid) && o_boot_mode == BSL_MODE_LINK
            |-> $past(i_link_boot_strap, 3))
        else $error("Link mode without link strap");
    a_none_starts:
        assert property ($rose(o_mode_valid) && o_boot_mode == BSL_MODE_NONE
            |-> o_core_start)
        else $error("No boot mode did not start at once");
    a_start_pulse:
        assert property (o_core_start |-> s_at_vector ##1 s_pulse_over)
        else $error("Core start pulse or vector wrong");
    a_load_ends:
        assert property (o_boot_load && i_boot_done |=> !o_boot_load
            && o_core_start)
        else $error("Load did not end on done");
    a_run_kept:
        assert property (o_instr_cycle_en |=> o_instr_cycle_en)
        else $error("Instruction cycles stopped");
    a_reserved_halt:
        assert property (o_reserved_err |-> !o_instr_cycle_en && !o_boot_load)
        else $error("Reserved straps did not halt");
endmodule : bsl_boot_ctrl_assertions

bind bsl_boot_ctrl bsl_boot_ctrl_assertions #(
    .P_RESET_VECTOR(P_RESET_VECTOR), .P_ADDR_W(P_ADDR_W)
) i_chk (
    .i_clock(i_clock), .i_rst_n(i_rst_n),
    .i_eprom_boot_strap(i_eprom_boot_strap),
    .i_link_boot_strap(i_link_boot_strap), .i_bus_master(i_bus_master),
    .i_boot_mem_req(i_boot_mem_req), .i_boot_done(i_boot_done),
    .o_boot_select_pin(o_boot_select_pin),
    .o_boot_select_oe(o_boot_select_oe), .o_boot_mode(o_boot_mode),
    .o_mode_valid(o_mode_valid), .o_reserved_err(o_reserved_err),
    .o_boot_load(o_boot_load), .o_core_start(o_core_start),
    .o_instr_cycle_en(o_instr_cycle_en), .o_fetch_addr(o_fetch_addr)
);

// file: bench/tb.sv
// Self-checking bench of the boot mode selector
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import bsl_pkg::*;

    localparam logic [23:0] VEC = 24'h000100;
    logic        i_clock  = 1'b0;
    logic        i_rst_n  = 1'b0;
    logic [2:0]  straps   = 3'h0;
    logic [7:0]  load_len = 8'h0A;
    logic        master   = 1'b0;
    logic        eprom_s, link_s, sel_w, mem_req, boot_done, pin_out;
    logic        pin_oe, mode_valid, res_err, boot_load, core_start;
    logic        run_en, changed;
    logic [23:0] fetch;
    bsl_mode_t   mode;
    int          num_errors = 0;
    int          checks     = 0;

    // Free running 100 MHz clock
    always #5 i_clock = ~i_clock;

    bsl_boot_ctrl #(.P_RESET_VECTOR(VEC), .P_ADDR_W(24)) i_dut (
        .i_clock(i_clock), .i_rst_n(i_rst_n),
        .i_eprom_boot_strap(eprom_s), .i_link_boot_strap(link_s),
        .i_boot_select_pin(sel_w), .o_boot_select_pin(pin_out),
        .o_boot_select_oe(pin_oe), .i_bus_master(master),
        .i_boot_mem_req(mem_req), .i_boot_done(boot_done),
        .o_boot_mode(mode), .o_mode_valid(mode_valid),
        .o_reserved_err(res_err), .o_boot_load(boot_load),
        .o_core_start(core_start), .o_instr_cycle_en(run_en),
        .o_fetch_addr(fetch), .o_strap_changed(changed));

    bsl_board_model i_board (
        .i_clock(i_clock), .i_straps(straps), .i_load_len(load_len),
        .i_pin_out(pin_out), .i_pin_oe(pin_oe), .i_boot_load(boot_load),
        .o_eprom_strap(eprom_s), .o_link_strap(link_s),
        .o_select_wire(sel_w), .o_mem_req(mem_req),
        .o_boot_done(boot_done));

    task automatic chk(input string name, input logic [23:0] exp,
                       input logic [23:0] got);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    // Reset with new straps, then wait a bounded time for the latch
    task automatic boot(input logic [2:0] s);
        @(negedge i_clock);
        i_rst_n = 1'b0;
        straps  = s;
        repeat (3) @(negedge i_clock);
        i_rst_n = 1'b1;
        for (int n = 0; n < 20 && mode_valid !== 1'b1; n++) @(negedge i_clock);
    endtask : boot

    // Pulse lasts one cycle, so every falling edge is looked at
    task automatic wait_start();
        for (int n = 0; n < 60 && core_start !== 1'b1; n++) @(negedge i_clock);
    endtask : wait_start

    task automatic t_none();
        boot(3'h0);
        chk("mode", BSL_MODE_NONE, mode);
        chk("start", 24'h1, core_start);
        chk("fetch", VEC, fetch);
        chk("load", 24'h0, boot_load);
        @(negedge i_clock);
        chk("run", 24'h1, run_en);
    endtask : t_none

    // Host boot, requests must never reach the pin; then a strap moves
    task automatic t_host();
        master = 1'b1;
        boot(3'h1);
        chk("mode", BSL_MODE_HOST, mode);
        chk("load", 24'h1, boot_load);
        repeat (2) @(negedge i_clock);
        chk("pin", 24'h1, pin_out);
        chk("oe", 24'h0, pin_oe);
        wait_start();
        chk("start", 24'h1, core_start);
        straps = 3'h3;
        repeat (5) @(negedge i_clock);
        chk("changed", 24'h1, changed);
        chk("mode", BSL_MODE_HOST, mode);
    endtask : t_host

    task automatic t_link();
        boot(3'h3);
        chk("mode", BSL_MODE_LINK, mode);
        wait_start();
        chk("start", 24'h1, core_start);
    endtask : t_link

    // Both select strap levels; bus ownership dropped mid load
    task automatic t_eprom();
        for (int i = 4; i < 6; i++) begin
            master = 1'b1;
            boot(3'(i));
            chk("mode", BSL_MODE_EPROM, mode);
            repeat (2) @(negedge i_clock);
            chk("oe", 24'h1, pin_oe);
            chk("pin", 24'h0, pin_out);
            master = 1'b0;
            repeat (2) @(negedge i_clock);
            chk("oe", 24'h0, pin_oe);
            chk("pin", 24'h1, pin_out);
            master = 1'b1;
            wait_start();
            chk("start", 24'h1, core_start);
        end
    endtask : t_eprom

    task automatic t_reserved();
        logic [2:0] rs [3] = '{3'h2, 3'h6, 3'h7};
        foreach (rs[i]) begin
            boot(rs[i]);
            chk("err", 24'h1, res_err);
            chk("mode", BSL_MODE_RESERVED, mode);
            repeat (10) @(negedge i_clock);
            chk("run", 24'h0, run_en);
        end
    endtask : t_reserved

    task automatic test_done();
        $display("errors %0d checks %0d", num_errors, checks);
        if (num_errors == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : test_done

    // Whole run needs under 1000 cycles; allow a wide margin
    initial begin
        #100000;
        num_errors++;
        test_done();
    end

    initial begin
        t_none();
        t_host();
        t_link();
        t_eprom();
        t_reserved();
        test_done();
    end
endmodule : tb
